/* rtl/match_capture_timer32_pkg.sv */
package match_capture_timer32_pkg;

  localparam int NUM_MATCH   = 4;      // Match registers and match outputs
  localparam int NUM_CAPTURE = 2;      // Capture inputs
  localparam int NUM_DMA     = 2;      // Matches able to request DMA
  localparam int NUM_FLAGS   = NUM_MATCH + NUM_CAPTURE;
  localparam int FLAG_MATCH0 = 0;      // Flags 0..3 are match events
  localparam int FLAG_CAP0   = 4;      // Flags 4..5 are capture events

  // Count source selections
  localparam logic [1:0] SRC_TIMER   = 2'h0;  // Every enabled clock cycle
  localparam logic [1:0] SRC_RISE    = 2'h1;  // Rising edges of external clock
  localparam logic [1:0] SRC_FALL    = 2'h2;  // Falling edges of external clock
  localparam logic [1:0] SRC_BOTH    = 2'h3;  // Both edges of external clock

  // Match output actions
  localparam logic [1:0] ACT_NONE    = 2'h0;
  localparam logic [1:0] ACT_LOW     = 2'h1;
  localparam logic [1:0] ACT_HIGH    = 2'h2;
  localparam logic [1:0] ACT_TOGGLE  = 2'h3;

  // Capture edge select bits
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  // Synchroniser bit positions
  localparam int SYNC_CAP0     = 0;
  localparam int SYNC_EXTCLK   = 2;
  localparam int SYNC_WIDTH    = 3;

  // Reset values
  localparam logic [31:0] RESET_COUNT = 32'h0000_0000;
  localparam logic [31:0] RESET_MATCH = 32'hffff_ffff;

endpackage

/* rtl/pin_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             clock_enable,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] stage1;  // Metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2;  // Second stage
  logic [WIDTH-1:0] stage3;  // Third stage, agreement check partner

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync3: WIDTH must be at least 1");
    end
  end

  // Three-flop chain
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (clock_enable) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accepted level changes only when the two late stages agree;
  // a single-cycle disagreement is treated as noise.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      level <= '0;
      rise  <= '0;
      fall  <= '0;
    end else if (clock_enable) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
          rise[i]  <= stage3[i] & ~level[i];
          fall[i]  <= ~stage3[i] & level[i];
        end else begin
          rise[i]  <= 1'b0;
          fall[i]  <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/match_capture_timer32.sv */
`timescale 1ns/1ps
`default_nettype none
module match_capture_timer32 #(
  parameter int COUNT_WIDTH = 32
) (
  input  wire logic                                   clock,
  input  wire logic                                   resetn,
  input  wire logic                                   clock_enable,
  // Count control
  input  wire logic                                   count_enable,
  input  wire logic                                   count_reset,
  input  wire logic [1:0]                             count_source,
  input  wire logic [COUNT_WIDTH-1:0]                 prescale_max,
  input  wire logic                                   count_clock_pin,
  // Match configuration
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0][COUNT_WIDTH-1:0] match_value,
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0] match_write,
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0] match_shadow_en,
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0] match_irq_en,
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0] match_stop_en,
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0] match_reset_en,
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0][1:0] match_action,
  input  wire logic [match_capture_timer32_pkg::NUM_MATCH-1:0] pwm_en,
  // Capture configuration
  input  wire logic [match_capture_timer32_pkg::NUM_CAPTURE-1:0] capture_pin,
  input  wire logic [match_capture_timer32_pkg::NUM_CAPTURE-1:0][1:0] capture_edge,
  input  wire logic [match_capture_timer32_pkg::NUM_CAPTURE-1:0] capture_irq_en,
  input  wire logic                                   clear_on_capture_en,
  input  wire logic                                   clear_capture_sel,
  input  wire logic [1:0]                             clear_capture_edge,
  // Flags
  input  wire logic [match_capture_timer32_pkg::NUM_FLAGS-1:0] flag_clear,
  // Results
  output logic      [COUNT_WIDTH-1:0]                 count,
  output logic      [COUNT_WIDTH-1:0]                 prescale_count,
  output logic      [match_capture_timer32_pkg::NUM_CAPTURE-1:0][COUNT_WIDTH-1:0] capture_value,
  output logic      [match_capture_timer32_pkg::NUM_MATCH-1:0] match_out,
  output logic      [match_capture_timer32_pkg::NUM_DMA-1:0] dma_request,
  output logic      [match_capture_timer32_pkg::NUM_FLAGS-1:0] irq_flags,
  output logic                                        irq,
  output logic                                        halted
);
  import match_capture_timer32_pkg::*;

  logic [NUM_MATCH-1:0][COUNT_WIDTH-1:0]   active_match;   // Values compared
  logic [NUM_MATCH-1:0][COUNT_WIDTH-1:0]   shadow_match;   // Pending values
  logic [NUM_MATCH-1:0]                    shadow_pending; // Shadow awaits load
  logic [SYNC_WIDTH-1:0]                   pin_level;      // Synchronised pins
  logic [SYNC_WIDTH-1:0]                   pin_rise;       // Accepted rising edges
  logic [SYNC_WIDTH-1:0]                   pin_fall;       // Accepted falling edges
  logic                                    tick;           // Prescaler input
  logic                                    advance;        // Count steps this cycle
  logic [NUM_MATCH-1:0]                    match_hit;      // Match events
  logic [NUM_CAPTURE-1:0]                  capture_hit;    // Capture events
  logic                                    capture_clear;  // Clear from capture
  logic                                    restart;        // Count returns to zero
  logic [NUM_FLAGS-1:0]                    flag_set;       // Flag set requests
  logic [NUM_FLAGS-1:0]                    next_irq_flags; // Flags after update

  // Check the width that the logic can serve
  initial begin
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin
      $error("match_capture_timer32: COUNT_WIDTH must be 2..32");
    end
  end

  // Edge test shared by capture and clear decoding
  function automatic logic edge_seen(input logic [1:0] sel, input logic r, input logic f);
    edge_seen = (sel[EDGE_RISE_BIT] & r) | (sel[EDGE_FALL_BIT] & f);
  endfunction

  // Pin synchronisers for the capture pins and the external clock
  pin_sync3 #(
    .WIDTH(SYNC_WIDTH)
  ) u_pin_sync (
    .clock        (clock),
    .resetn       (resetn),
    .clock_enable (clock_enable),
    .pin          ({count_clock_pin, capture_pin}),
    .level        (pin_level),
    .rise         (pin_rise),
    .fall         (pin_fall)
  );

  // Event decode for count source, matches and captures
  always_comb begin
    unique case (count_source)
      SRC_TIMER: tick = 1'b1;
      SRC_RISE:  tick = pin_rise[SYNC_EXTCLK];
      SRC_FALL:  tick = pin_fall[SYNC_EXTCLK];
      SRC_BOTH:  tick = pin_rise[SYNC_EXTCLK] | pin_fall[SYNC_EXTCLK];
    endcase
    tick    = tick & count_enable & ~halted;
    // Count steps when the prescaler wraps
    advance = tick && (prescale_count == prescale_max);
    for (int i = 0; i < NUM_MATCH; i++) begin
      // Event when the count leaves the matched value
      match_hit[i] = advance && (count == active_match[i]);
    end
    for (int i = 0; i < NUM_CAPTURE; i++) begin
      capture_hit[i] = edge_seen(capture_edge[i], pin_rise[SYNC_CAP0 + i],
                                 pin_fall[SYNC_CAP0 + i]);
    end
    capture_clear = clear_on_capture_en &&
                    edge_seen(clear_capture_edge, pin_rise[SYNC_CAP0 + int'(clear_capture_sel)],
                              pin_fall[SYNC_CAP0 + int'(clear_capture_sel)]);
    restart = count_reset | capture_clear | (|(match_hit & match_reset_en));
  end

  // Prescaler and main count
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prescale_count <= '0;
      count          <= RESET_COUNT[COUNT_WIDTH-1:0];
    end else if (clock_enable) begin
      if (count_reset || capture_clear) begin
        // Software or capture clear resets both stages
        prescale_count <= '0;
        count          <= '0;
      end else if (tick) begin
        if (advance) begin
          prescale_count <= '0;
          if (|(match_hit & match_reset_en)) begin
            count <= '0;
          end else begin
            count <= count + 1'b1;
          end
        end else begin
          prescale_count <= prescale_count + 1'b1;
        end
      end
    end
  end

  // Halt on a stop match; dropping count_enable re-arms the counter
  always_ff @(posedge clock) begin
    if (!resetn) begin
      halted <= 1'b0;
    end else if (clock_enable) begin
      if (|(match_hit & match_stop_en)) begin
        halted <= 1'b1;
      end else if (!count_enable) begin
        halted <= 1'b0;
      end
    end
  end

  // Match value loading; shadowed values wait for the period restart so a
  // running PWM cycle never sees a half-updated threshold
  always_ff @(posedge clock) begin
    if (!resetn) begin
      active_match   <= {NUM_MATCH{RESET_MATCH[COUNT_WIDTH-1:0]}};
      shadow_match   <= {NUM_MATCH{RESET_MATCH[COUNT_WIDTH-1:0]}};
      shadow_pending <= '0;
    end else if (clock_enable) begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        if (match_write[i] && !match_shadow_en[i]) begin
          active_match[i]   <= match_value[i];  // Direct load
          shadow_pending[i] <= 1'b0;
        end else if (match_write[i]) begin
          shadow_match[i]   <= match_value[i];
          shadow_pending[i] <= 1'b1;
        end else if (restart && shadow_pending[i]) begin
          active_match[i]   <= shadow_match[i];
          shadow_pending[i] <= 1'b0;
        end
      end
    end
  end

  // Match outputs; PWM channels drop at restart and rise at their match
  always_ff @(posedge clock) begin
    if (!resetn) begin
      match_out <= '0;
    end else if (clock_enable) begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        if (pwm_en[i]) begin
          if (match_hit[i]) begin
            match_out[i] <= 1'b1;
          end else if (restart) begin
            match_out[i] <= 1'b0;
          end
        end else if (match_hit[i]) begin
          unique case (match_action[i])
            ACT_NONE:   match_out[i] <= match_out[i];
            ACT_LOW:    match_out[i] <= 1'b0;
            ACT_HIGH:   match_out[i] <= 1'b1;
            ACT_TOGGLE: match_out[i] <= ~match_out[i];
          endcase
        end
      end
    end
  end

  // DMA requests are one-cycle pulses on the first two matches
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dma_request <= '0;
    end else if (clock_enable) begin
      dma_request <= match_hit[NUM_DMA-1:0];
    end
  end

  // Capture registers take the count as it stands at the event
  always_ff @(posedge clock) begin
    if (!resetn) begin
      capture_value <= '0;
    end else if (clock_enable) begin
      for (int i = 0; i < NUM_CAPTURE; i++) begin
        if (capture_hit[i]) begin
          capture_value[i] <= count;
        end
      end
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  always_comb begin
    flag_set = '0;
    for (int i = 0; i < NUM_MATCH; i++) begin
      flag_set[FLAG_MATCH0 + i] = match_hit[i] & match_irq_en[i];
    end
    for (int i = 0; i < NUM_CAPTURE; i++) begin
      flag_set[FLAG_CAP0 + i] = capture_hit[i] & capture_irq_en[i];
    end
    next_irq_flags = flag_set | (irq_flags & ~flag_clear);
  end

  // Flag register and combined interrupt, both registered
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_flags <= '0;
      irq       <= 1'b0;
    end else if (clock_enable) begin
      irq_flags <= next_irq_flags;
      irq       <= |next_irq_flags;
    end
  end

endmodule
`default_nettype wire

/* verification/match_capture_timer32_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module match_capture_timer32_properties #(
  parameter int COUNT_WIDTH = 32
) (
  input wire logic                        clock,
  input wire logic                        resetn,
  input wire logic                        clock_enable,
  input wire logic                        count_enable,
  input wire logic                        count_reset,
  input wire logic                        clear_on_capture_en,
  input wire logic [1:0]                  capture_pin,
  input wire logic [5:0]                  flag_clear,
  input wire logic [COUNT_WIDTH-1:0]      count,
  input wire logic [1:0][COUNT_WIDTH-1:0] capture_value,
  input wire logic [1:0]                  dma_request,
  input wire logic [5:0]                  irq_flags,
  input wire logic                        irq,
  input wire logic                        halted
);
  // One clock domain, one reset
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_count_step;
    clock_enable |=> count == $past(count) + 1'b1 || count == '0 || $stable(count);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped");
  property p_count_hold;
    clock_enable && !count_enable && !count_reset && !clear_on_capture_en |=> $stable(count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved");
  property p_count_clear;
    clock_enable && count_reset |=> count == '0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count not cleared");
  property p_halt_hold;
    halted && !count_reset && !clear_on_capture_en |=> $stable(count);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halted count moved");
  property p_halt_release;
    clock_enable && !count_enable |=> !halted;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt kept");
  property p_irq_or;
    irq == |irq_flags;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not flag or");
  // Guarded by past reset, since flags before reset may have been set
  property p_flag_sticky;
    $past(resetn) |-> (($past(irq_flags) & ~irq_flags & ~$past(flag_clear)) == 6'h00);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
  property p_dma;
    dma_request[0] |-> count != $past(count) || halted;
  endproperty
  a_dma: assert property (p_dma) else $error("dma without match step");
  // A new capture is seen five samples after the pin moved: three sync flops,
  // the level flop, the capture flop
  property p_capture;
    $past(resetn) && capture_value[0] != $past(capture_value[0])
      |-> $past(capture_pin[0], 5) != $past(capture_pin[0], 6);
  endproperty
  a_capture: assert property (p_capture) else $error("capture without edge");
endmodule
bind match_capture_timer32 match_capture_timer32_properties #(.COUNT_WIDTH(COUNT_WIDTH)) props (
  .clock(clock), .resetn(resetn), .clock_enable(clock_enable), .count_enable(count_enable),
  .count_reset(count_reset), .clear_on_capture_en(clear_on_capture_en),
  .capture_pin(capture_pin), .flag_clear(flag_clear), .count(count),
  .capture_value(capture_value), .dma_request(dma_request), .irq_flags(irq_flags),
  .irq(irq), .halted(halted));
`default_nettype wire

/* verification/ext_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model (
  input  wire logic clock,
  output logic      count_clock_pin,
  output logic [1:0] capture_pin
);
  // Pins idle low; the external clock stands still between bursts
  initial begin
    count_clock_pin = 1'b0;
    capture_pin = 2'h0;
  end
  // Slow external clock, three system cycles per phase
  task automatic clock_burst(input int n);
    repeat (n) begin
      repeat (3) @(negedge clock);
      count_clock_pin = 1'b1;
      repeat (3) @(negedge clock);
      count_clock_pin = 1'b0;
    end
  endtask
  task automatic set_capture(input int idx, input logic level);
    @(negedge clock);
    capture_pin[idx] = level;
  endtask
endmodule
`default_nettype wire

/* verification/match_capture_timer32_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module match_capture_timer32_tb;
  import match_capture_timer32_pkg::*;
  logic clock, resetn, clock_enable, count_enable, count_reset, count_clock_pin;
  logic clear_on_capture_en, clear_capture_sel, halted, irq;
  logic [1:0] count_source, clear_capture_edge, capture_pin, capture_irq_en, dma_request;
  logic [31:0] prescale_max, count, prescale_count;
  logic [3:0][31:0] match_value;
  logic [3:0] match_write, match_shadow_en, match_irq_en, match_stop_en, match_reset_en, match_out;
  logic [3:0] pwm_en;
  logic [3:0][1:0] match_action;
  logic [1:0][1:0] capture_edge;
  logic [1:0][31:0] capture_value;
  logic [5:0] flag_clear, irq_flags;
  wire [7:0] events = {dma_request, irq_flags};
  int miscompares, comparisons, n, c;
  ext_pin_model ext (.clock(clock), .count_clock_pin(count_clock_pin), .capture_pin(capture_pin));
  match_capture_timer32 uut (.clock(clock), .resetn(resetn), .clock_enable(clock_enable),
    .count_enable(count_enable), .count_reset(count_reset), .count_source(count_source),
    .prescale_max(prescale_max), .count_clock_pin(count_clock_pin), .match_value(match_value),
    .match_write(match_write), .match_shadow_en(match_shadow_en), .match_irq_en(match_irq_en),
    .match_stop_en(match_stop_en), .match_reset_en(match_reset_en), .match_action(match_action),
    .pwm_en(pwm_en), .capture_pin(capture_pin), .capture_edge(capture_edge),
    .capture_irq_en(capture_irq_en), .clear_on_capture_en(clear_on_capture_en),
    .clear_capture_sel(clear_capture_sel), .clear_capture_edge(clear_capture_edge),
    .flag_clear(flag_clear), .count(count), .prescale_count(prescale_count),
    .capture_value(capture_value), .match_out(match_out), .dma_request(dma_request),
    .irq_flags(irq_flags), .irq(irq), .halted(halted));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait for an event bit; n counts the edges it took
  task automatic wait_hit(input int b);
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (events[b] !== 1'b1 && n < 300);
    if (n >= 300) check("event wait", 1, 0);
  endtask
  task automatic set_match(input int i, input logic [31:0] v, input logic ie, st, rs,
                           input logic [1:0] act, input logic sh);
    @(negedge clock);
    match_value[i] = v;
    {match_irq_en[i], match_stop_en[i], match_reset_en[i], match_shadow_en[i]} = {ie, st, rs, sh};
    match_action[i] = act;
    match_write[i] = 1'b1;
    @(negedge clock);
    match_write[i] = 1'b0;
  endtask
  task automatic restart(input logic [31:0] ps, input logic [1:0] src);
    @(negedge clock);
    {prescale_max, count_source, count_reset, count_enable} = {ps, src, 2'b11};
    @(negedge clock);
    count_reset = 1'b0;
  endtask
  task automatic clear_flags();
    @(negedge clock);
    flag_clear = 6'h3f;
    @(negedge clock);
    flag_clear = 6'h00;
  endtask
  // Freeze the count so that reprogramming cannot fire stale matches
  task automatic pause();
    @(negedge clock);
    count_enable = 1'b0;
  endtask
  task automatic t_walk();
    check("reset count", 0, count);
    set_match(0, 2, 1, 0, 1, ACT_TOGGLE, 0);
    restart(1, SRC_TIMER);
    wait_hit(6);
    check("walk count", 0, count);
    check("walk prescale", 0, prescale_count);
    check("walk flag", 3, {irq_flags[0], irq});
    check("walk out", 1, match_out[0]);
    @(posedge clock);
    #1 check("dma pulse", 0, dma_request[0]);
    wait_hit(6);
    check("walk period", 5, n);
    check("walk out back", 0, match_out[0]);
    clear_flags();
    check("flag cleared", 0, irq_flags[0]);
    $display("walk done");
  endtask
  task automatic t_actions();
    pause();
    set_match(0, 2, 0, 0, 0, ACT_HIGH, 0);
    set_match(1, 4, 0, 0, 0, ACT_TOGGLE, 0);
    set_match(2, 6, 0, 0, 0, ACT_HIGH, 0);
    set_match(3, 9, 1, 0, 1, ACT_NONE, 0);
    restart(0, SRC_TIMER);
    clear_flags();
    wait_hit(3);
    check("actions one", 4'h7, match_out);
    set_match(2, 6, 0, 0, 0, ACT_LOW, 0);
    clear_flags();
    wait_hit(3);
    check("actions two", 4'h1, match_out);
    $display("actions done");
  endtask
  task automatic t_stop();
    pause();
    set_match(1, 4, 1, 1, 0, ACT_NONE, 0);
    restart(0, SRC_TIMER);
    clear_flags();
    wait_hit(1);
    check("halted", 1, halted);
    c = count;
    repeat (5) @(posedge clock);
    #1 check("halt count", c, count);
    pause();
    @(negedge clock);
    check("halt release", 0, halted);
    set_match(1, 32'hffff_ffff, 0, 0, 0, ACT_NONE, 0);
    set_match(3, 32'hffff_ffff, 0, 0, 0, ACT_NONE, 0);
    $display("stop done");
  endtask
  task automatic t_ext();
    for (int s = 1; s < 4; s++) begin
      restart(0, s[1:0]);
      ext.clock_burst(5);
      repeat (6) @(negedge clock);
      check("ext count", s == 3 ? 10 : 5, count);
    end
    $display("ext done");
  endtask
  task automatic t_capture();
    restart(0, SRC_TIMER);
    {capture_edge, capture_irq_en} = {2'b10, 2'b01, 2'b11};
    clear_flags();
    ext.set_capture(0, 1'b1);
    c = count;
    repeat (7) @(posedge clock);
    #1 n = capture_value[0] - c;
    check("capture delay", 1, n == 4 || n == 5);
    check("capture flag", 1, irq_flags[4]);
    @(negedge clock);
    {clear_on_capture_en, clear_capture_sel, clear_capture_edge} = 4'b1110;
    ext.set_capture(1, 1'b1);
    repeat (8) @(negedge clock);
    ext.set_capture(1, 1'b0);
    repeat (8) @(posedge clock);
    #1 check("clear count", 1, count == 2 || count == 3);
    check("second capture", 1, capture_value[1] > 8);
    @(negedge clock);
    clear_on_capture_en = 1'b0;
    $display("capture done");
  endtask
  task automatic t_shadow();
    set_match(0, 5, 1, 0, 1, ACT_NONE, 0);
    restart(0, SRC_TIMER);
    wait_hit(6);
    wait_hit(6);
    check("period", 6, n);
    set_match(0, 2, 1, 0, 1, ACT_NONE, 1);
    wait_hit(6);
    check("shadow old", 5, n);
    wait_hit(6);
    check("shadow new", 3, n);
    $display("shadow done");
  endtask
  // PWM on match 1 with match 3 as period, then a clock-enable freeze
  task automatic t_pwm();
    pause();
    set_match(0, 32'hffff_ffff, 0, 0, 0, ACT_NONE, 0);
    set_match(3, 9, 0, 0, 1, ACT_NONE, 0);
    set_match(1, 4, 0, 0, 0, ACT_NONE, 0);
    pwm_en = 4'h2;
    restart(0, SRC_TIMER);
    wait_hit(7);
    check("pwm high", 1, match_out[1]);
    repeat (4) @(posedge clock);
    #1 check("pwm held", 1, match_out[1]);
    @(posedge clock);
    #1 check("pwm low", 0, match_out[1]);
    @(negedge clock);
    clock_enable = 1'b0;
    c = count;
    repeat (3) @(negedge clock);
    check("frozen count", c, count);
    clock_enable = 1'b1;
    $display("pwm done");
  endtask
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under 20 us
  initial begin
    #200us;
    miscompares++;
    final_report();
  end
  initial begin
    {resetn, count_enable, count_reset, count_source, prescale_max} = '0;
    clock_enable = 1'b1;
    pwm_en = 4'h0;
    {match_value, match_write, match_shadow_en, match_irq_en} = '0;
    {match_stop_en, match_reset_en, match_action, capture_edge, capture_irq_en} = '0;
    {clear_on_capture_en, clear_capture_sel, clear_capture_edge, flag_clear} = '0;
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    t_walk();
    t_actions();
    t_stop();
    t_ext();
    t_capture();
    t_shadow();
    t_pwm();
    final_report();
  end
endmodule
`default_nettype wire
